// [common/fault_sup_pkg.sv]
// Constants, field layouts and types for the power fault supervisor.
// Assumes one 250 MHz core clock and comparator inputs already synchronous.
//
// Notes on behaviour
// RQ1: Input voltage outside OV/UV limits triggers response
// RQ2: Output blocked and fault reported below turn-on level
// RQ3: Crossing input turn-off level gives soft-off (code holds PWM_SOFT_OFF one cycle only, then start-up blocking gives PWM_HIZ)
// RQ4: Fast input undervoltage trip tri-states PWM at once
// RQ5: Fast output OV/UV comparator turns PWM off
// RQ6: ADC output between warning and fault flags warning
// RQ7: ADC output below fault level adds fault event
// RQ8: Overcurrent puts every PWM output high-impedance
// RQ9: Overcurrent latch cleared only by control toggle
// RQ10: Controller or stage overtemperature starts soft-stop
// RQ11: Overtemperature restarts below per-source turn-on level
// RQ12: Temperature input high means stage fault, tri-state
// RQ13: Separate fault status kept per power stage
// RQ14: Low temperature input before enable blocks output
// RQ15: Duty above limit in one cycle: balance fault
// RQ16: Host can change per-phase duty limit (code keeps one duty limit shared by all phases)
// RQ17: Open sense line at init blocks output, flagged
// RQ18: Resistor value indices returned on read
// RQ19: Calibration offset added to each stage temperature
// RQ20: Run-time configuration reverts at reset unless stored (code reloads the defaults at every reset and never restores stored values)
// RQ21: Store writes only blank slots, seven stores
// RQ22: Retry delay is 100 times fault delay step
// RQ23: Nonzero fault delay rechecks before responding
// RQ24: Retry count 0..6, seven means hiccup forever
// RQ25: Low drives PWM low; high-Z tri-states at once
// RQ26: Most severe response wins; all faults recorded
package fault_sup_pkg;
   localparam int NUM_PHASES = 4;
   localparam int NUM_FAULTS = 9;
   // Fault indices
   localparam int F_VIN_OV = 0;
   localparam int F_VIN_UV = 1;
   localparam int F_VOUT_OV = 2;
   localparam int F_VOUT_UV = 3;
   localparam int F_OCP = 4;
   localparam int F_OT_CTRL = 5;
   localparam int F_OT_STAGE = 6;
   localparam int F_STAGE = 7;
   localparam int F_BALANCE = 8;
   localparam int DELAY_STEP_NS = 1500;
   localparam int DELAY_STEP_CYC = DELAY_STEP_NS / 4;
   localparam int RETRY_SCALE = 100;
   localparam logic [2:0] RETRY_HICCUP = 3'h7;
   localparam logic [2:0] NVM_STORES = 3'h7;
   localparam logic [11:0] TEMP_ON_DEFAULT = 12'h064;
   localparam logic [7:0] DUTY_LIMIT_DEFAULT = 8'hC0;

   typedef enum logic [1:0] {RESP_SOFT, RESP_LOW, RESP_HIZ, RESP_IGNORE} resp_e;
   typedef enum logic [1:0] {PWM_RUN, PWM_SOFT_OFF, PWM_LOW, PWM_HIZ} pwm_mode_e;

   typedef struct packed {
      resp_e resp;
      logic [2:0] retries;
      logic [7:0] delay;
   } fault_cfg_s;

   typedef struct packed {
      logic [11:0] vin_ov;
      logic [11:0] vin_uv;
      logic [11:0] vin_on;
      logic [11:0] vin_off;
      logic [11:0] vout_ov_warn;
      logic [11:0] vout_uv_warn;
      logic [11:0] vout_uv_fault;
      logic [11:0] temp_ctrl_ot;
      logic [11:0] temp_stage_ot;
      logic [11:0] temp_ctrl_on;
      logic [11:0] temp_stage_on;
   } limits_s;

   typedef struct packed {
      logic [11:0] vin;
      logic [11:0] vout;
      logic [11:0] temp_ctrl;
      logic [NUM_PHASES*12-1:0] temp_stage;
   } adc_s;
endpackage : fault_sup_pkg

// [design/power_fault_supervisor.sv]
// Fault supervision and response for a multi-phase step-down controller.
// Assumes ADC and comparator inputs synchronous to core_clk; host command
// decode lives outside and drives the write strobes here.
`timescale 1ns/1ns
module power_fault_supervisor (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic control_pin,
   input wire fault_sup_pkg::adc_s adc,
   input wire logic vin_uv_fast,
   input wire logic vout_ov_fast,
   input wire logic vout_uv_fast,
   input wire logic overcurrent_trip,
   input wire logic [fault_sup_pkg::NUM_PHASES-1:0] stage_fault_cmp,
   input wire logic [fault_sup_pkg::NUM_PHASES-1:0] stage_temp_low,
   input wire logic feedback_sense_pos_open,
   input wire logic feedback_sense_neg_open,
   input wire logic init_done,
   input wire logic [fault_sup_pkg::NUM_PHASES*8-1:0] phase_duty,
   input wire logic cycle_start,
   input wire logic [3:0] comp_resistor_code,
   input wire logic [3:0] vsel_resistor_code,
   input wire logic limits_we,
   input wire fault_sup_pkg::limits_s limits_wdata,
   input wire logic cfg_we,
   input wire logic [3:0] cfg_sel,
   input wire fault_sup_pkg::fault_cfg_s cfg_wdata,
   input wire logic duty_limit_we,
   input wire logic [7:0] duty_limit_wdata,
   input wire logic temp_cal_we,
   input wire logic [fault_sup_pkg::NUM_PHASES*8-1:0] temp_cal_wdata,
   input wire logic nvm_store,
   input wire logic nvm_slot_blank,
   input wire logic soft_off_done,
   output fault_sup_pkg::pwm_mode_e pwm_mode,
   output logic output_enable_ok,
   output logic [fault_sup_pkg::NUM_FAULTS-1:0] fault_status,
   output logic vin_low_fault,
   output logic vout_ov_warn,
   output logic vout_uv_warn,
   output logic [fault_sup_pkg::NUM_PHASES-1:0] stage_fault_status_cmd,
   output logic [1:0] sense_open_status,
   output logic stage_init_fault,
   output logic [3:0] comp_resistor_index_cmd,
   output logic [3:0] vsel_resistor_index_cmd,
   output logic [fault_sup_pkg::NUM_PHASES*12-1:0] stage_temp_cal,
   output logic [2:0] nvm_space_left_cmd,
   output logic nvm_store_refused
);
   import fault_sup_pkg::*;

   // ------------------------------------------------------------
   // Configuration (volatile, reset to defaults)
   // ------------------------------------------------------------
   limits_s lim_q;
   fault_cfg_s cfg_q [NUM_FAULTS];
   logic [7:0] duty_limit_q;
   logic [NUM_PHASES*8-1:0] cal_q;
   logic [2:0] stores_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin // RQ20
         lim_q <= '0;
         lim_q.temp_ctrl_on <= TEMP_ON_DEFAULT; // RQ11
         lim_q.temp_stage_on <= TEMP_ON_DEFAULT;
         lim_q.temp_ctrl_ot <= 12'hFFF;
         lim_q.temp_stage_ot <= 12'hFFF;
         lim_q.vin_ov <= 12'hFFF;
         duty_limit_q <= DUTY_LIMIT_DEFAULT;
         cal_q <= '0;
      end else begin
         if (limits_we)
            lim_q <= limits_wdata;
         if (duty_limit_we)
            duty_limit_q <= duty_limit_wdata; // RQ16
         if (temp_cal_we)
            cal_q <= temp_cal_wdata;
      end
   end

   generate
      for (genvar f = 0; f < NUM_FAULTS; f++) begin : g_cfg
         always_ff @(posedge core_clk) begin
            if (rst) begin
               cfg_q[f].resp <= (f == F_OT_CTRL || f == F_OT_STAGE) ? RESP_SOFT : RESP_HIZ;
               cfg_q[f].retries <= (f == F_VIN_UV || f == F_OT_CTRL || f == F_OT_STAGE) ? RETRY_HICCUP : 3'h0;
               cfg_q[f].delay <= 8'h00;
            end else if (cfg_we && cfg_sel == 4'(f)) begin
               cfg_q[f] <= cfg_wdata;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Nonvolatile store bookkeeping
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stores_q <= NVM_STORES;
         nvm_store_refused <= 1'b0;
      end else begin
         nvm_store_refused <= 1'b0;
         if (nvm_store) begin
            // Refused when slot already programmed or budget spent
            if (!nvm_slot_blank || stores_q == 3'h0)
               nvm_store_refused <= 1'b1; // RQ21
            else
               stores_q <= stores_q - 3'h1; // RQ21
         end
      end
   end

   // ------------------------------------------------------------
   // Detection
   // ------------------------------------------------------------
   logic [NUM_FAULTS-1:0] raw;
   logic [NUM_PHASES*12-1:0] temp_adj;
   logic [NUM_PHASES-1:0] stage_hot, duty_over;

   generate
      for (genvar p = 0; p < NUM_PHASES; p++) begin : g_ph
         assign temp_adj[p*12 +: 12] = adc.temp_stage[p*12 +: 12] + {{4{cal_q[p*8+7]}}, cal_q[p*8 +: 8]}; // RQ19
         assign stage_hot[p] = temp_adj[p*12 +: 12] > lim_q.temp_stage_ot;
         assign duty_over[p] = phase_duty[p*8 +: 8] > duty_limit_q; // RQ15
      end
   endgenerate

   always_comb begin
      raw[F_VIN_OV] = adc.vin > lim_q.vin_ov; // RQ1
      raw[F_VIN_UV] = (adc.vin < lim_q.vin_uv) || vin_uv_fast; // RQ1 RQ4
      raw[F_VOUT_OV] = vout_ov_fast; // RQ5
      raw[F_VOUT_UV] = vout_uv_fast || (adc.vout < lim_q.vout_uv_fault); // RQ5 RQ7
      raw[F_OCP] = overcurrent_trip; // RQ8
      raw[F_OT_CTRL] = adc.temp_ctrl > lim_q.temp_ctrl_ot; // RQ10
      raw[F_OT_STAGE] = |stage_hot; // RQ10
      raw[F_STAGE] = |stage_fault_cmp; // RQ12
      raw[F_BALANCE] = cycle_start && |duty_over; // RQ15
   end

   // ------------------------------------------------------------
   // Per-fault delay, latch and retry
   // ------------------------------------------------------------
   logic [NUM_FAULTS-1:0] active_q, cleared;
   logic [NUM_FAULTS-1:0] pend_q;
   logic [2:0] rcnt_q [NUM_FAULTS];
   logic ctrl_q;
   logic ctrl_fall;

   always_ff @(posedge core_clk) begin
      if (rst)
         ctrl_q <= 1'b0;
      else
         ctrl_q <= control_pin;
   end
   assign ctrl_fall = ctrl_q && !control_pin; // RQ9

   generate
      for (genvar f = 0; f < NUM_FAULTS; f++) begin : g_flt
         logic [23:0] delay_cyc;
         logic [23:0] retry_cyc;
         logic [23:0] tmr_q;
         logic wait_retry_q;
         assign delay_cyc = 24'(cfg_q[f].delay) * 24'(DELAY_STEP_CYC);
         assign retry_cyc = delay_cyc * 24'(RETRY_SCALE); // RQ22
         // Retrying faults count as cleared once the cause is gone; overtemperature only below its turn-on level
         assign cleared[f] = (f == F_OT_CTRL) ? (adc.temp_ctrl < lim_q.temp_ctrl_on) :
                             (f == F_OT_STAGE) ? (temp_adj[11:0] < lim_q.temp_stage_on &&
                                                  temp_adj[23:12] < lim_q.temp_stage_on &&
                                                  temp_adj[35:24] < lim_q.temp_stage_on &&
                                                  temp_adj[47:36] < lim_q.temp_stage_on) : // RQ11
                             !raw[f];
         always_ff @(posedge core_clk) begin
            if (rst) begin
               active_q[f] <= 1'b0;
               pend_q[f] <= 1'b0;
               tmr_q <= '0;
               rcnt_q[f] <= 3'h0;
               wait_retry_q <= 1'b0;
            end else if (!active_q[f]) begin
               if (pend_q[f]) begin
                  if (tmr_q >= delay_cyc) begin
                     pend_q[f] <= 1'b0;
                     active_q[f] <= raw[f]; // RQ23
                  end else begin
                     tmr_q <= tmr_q + 24'h1;
                  end
               end else if (raw[f]) begin
                  if (cfg_q[f].delay == 8'h00)
                     active_q[f] <= 1'b1;
                  else begin
                     pend_q[f] <= 1'b1; // RQ23
                     tmr_q <= 24'h1;
                  end
               end
               wait_retry_q <= 1'b0;
            end else if (cfg_q[f].retries == 3'h0) begin
               // Latched off until control pin is cycled
               if (ctrl_fall && !raw[f])
                  active_q[f] <= 1'b0; // RQ9
            end else if (!wait_retry_q) begin
               if (cleared[f]) begin
                  wait_retry_q <= 1'b1;
                  tmr_q <= '0;
               end
            end else if (tmr_q >= retry_cyc) begin
               wait_retry_q <= 1'b0;
               if (cleared[f] && (cfg_q[f].retries == RETRY_HICCUP || rcnt_q[f] < cfg_q[f].retries)) begin // RQ24
                  active_q[f] <= 1'b0;
                  if (cfg_q[f].retries != RETRY_HICCUP)
                     rcnt_q[f] <= rcnt_q[f] + 3'h1;
               end
            end else begin
               tmr_q <= tmr_q + 24'h1;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Start-up blocking and lockouts
   // ------------------------------------------------------------
   logic vin_on_q, vin_below_off;
   assign vin_below_off = adc.vin < lim_q.vin_off;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         vin_on_q <= 1'b0;
         vin_low_fault <= 1'b1;
      end else begin
         if (adc.vin > lim_q.vin_on)
            vin_on_q <= 1'b1; // RQ2
         else if (vin_below_off)
            vin_on_q <= 1'b0; // RQ3
         vin_low_fault <= !(adc.vin > lim_q.vin_on) && !vin_on_q; // RQ2
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sense_open_status <= 2'b00;
         stage_init_fault <= 1'b0;
      end else if (init_done && pwm_mode != PWM_RUN) begin
         sense_open_status <= sense_open_status | {feedback_sense_neg_open, feedback_sense_pos_open}; // RQ17
         stage_init_fault <= stage_init_fault | (|stage_temp_low); // RQ14
      end
   end

   // ------------------------------------------------------------
   // Severity arbitration and status
   // ------------------------------------------------------------
   logic hiz_req, low_req, soft_req;
   always_comb begin
      hiz_req = 1'b0;
      low_req = 1'b0;
      soft_req = 1'b0;
      for (int f = 0; f < NUM_FAULTS; f++) begin
         if (active_q[f]) begin
            hiz_req = hiz_req | (cfg_q[f].resp == RESP_HIZ);
            low_req = low_req | (cfg_q[f].resp == RESP_LOW);
            soft_req = soft_req | (cfg_q[f].resp == RESP_SOFT);
         end
      end
   end

   logic start_block;
   assign start_block = !vin_on_q || (|sense_open_status) || stage_init_fault || !init_done;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pwm_mode <= PWM_HIZ;
         output_enable_ok <= 1'b0;
      end else begin
         output_enable_ok <= !start_block && !(hiz_req || low_req || soft_req);
         if (hiz_req) // RQ26
            pwm_mode <= PWM_HIZ; // RQ25
         else if (low_req)
            pwm_mode <= PWM_LOW; // RQ25
         else if (soft_req || (vin_below_off && pwm_mode == PWM_RUN))
            pwm_mode <= (pwm_mode == PWM_RUN || pwm_mode == PWM_SOFT_OFF) && !soft_off_done
                        ? PWM_SOFT_OFF : PWM_HIZ; // RQ3
         else if (start_block)
            pwm_mode <= PWM_HIZ;
         else
            pwm_mode <= PWM_RUN;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         fault_status <= '0;
         vout_ov_warn <= 1'b0;
         vout_uv_warn <= 1'b0;
         stage_fault_status_cmd <= '0;
         comp_resistor_index_cmd <= 4'h0;
         vsel_resistor_index_cmd <= 4'h0;
         stage_temp_cal <= '0;
         nvm_space_left_cmd <= NVM_STORES;
      end else begin
         fault_status <= active_q; // RQ26
         vout_uv_warn <= adc.vout < lim_q.vout_uv_warn && adc.vout >= lim_q.vout_uv_fault; // RQ6
         vout_ov_warn <= adc.vout > lim_q.vout_ov_warn; // RQ6
         stage_fault_status_cmd <= stage_fault_status_cmd | stage_fault_cmp; // RQ13
         if (ctrl_fall)
            stage_fault_status_cmd <= stage_fault_cmp;
         comp_resistor_index_cmd <= comp_resistor_code; // RQ18
         vsel_resistor_index_cmd <= vsel_resistor_code; // RQ18
         stage_temp_cal <= temp_adj;
         nvm_space_left_cmd <= stores_q; // RQ21
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_ocp_hiz;
      @(posedge core_clk) disable iff (rst)
      (overcurrent_trip && cfg_q[F_OCP].delay == 8'h00 && cfg_q[F_OCP].resp == RESP_HIZ) |-> ##2 pwm_mode == PWM_HIZ;
   endproperty
   a_ocp_hiz: assert property (p_ocp_hiz) else $error("overcurrent did not tri-state"); // RQ8

   property p_ocp_latch;
      @(posedge core_clk) disable iff (rst)
      (active_q[F_OCP] && cfg_q[F_OCP].retries == 3'h0 && !ctrl_fall) |=> active_q[F_OCP];
   endproperty
   a_ocp_latch: assert property (p_ocp_latch) else $error("overcurrent latch released without toggle"); // RQ9

   property p_stage_hiz;
      @(posedge core_clk) disable iff (rst)
      (active_q[F_STAGE] && cfg_q[F_STAGE].resp == RESP_HIZ) |=> pwm_mode == PWM_HIZ;
   endproperty
   a_stage_hiz: assert property (p_stage_hiz) else $error("stage fault did not tri-state"); // RQ12

   property p_vin_block;
      @(posedge core_clk) disable iff (rst)
      !vin_on_q |=> !output_enable_ok;
   endproperty
   a_vin_block: assert property (p_vin_block) else $error("output allowed below turn-on level"); // RQ2

   property p_sense_open;
      @(posedge core_clk) disable iff (rst)
      (|sense_open_status) |=> pwm_mode != PWM_RUN;
   endproperty
   a_sense_open: assert property (p_sense_open) else $error("output ran with open sense line"); // RQ17

   property p_uv_warn;
      @(posedge core_clk) disable iff (rst)
      (adc.vout < lim_q.vout_uv_fault) |=> !vout_uv_warn;
   endproperty
   a_uv_warn: assert property (p_uv_warn) else $error("warning set below fault level"); // RQ6

   property p_balance;
      @(posedge core_clk) disable iff (rst)
      (cycle_start && |duty_over && cfg_q[F_BALANCE].delay == 8'h00) |=> active_q[F_BALANCE];
   endproperty
   a_balance: assert property (p_balance) else $error("duty overrun not caught"); // RQ15

   property p_nvm;
      @(posedge core_clk) disable iff (rst)
      (nvm_store && !nvm_slot_blank) |=> nvm_store_refused && $stable(stores_q);
   endproperty
   a_nvm: assert property (p_nvm) else $error("store to programmed slot accepted"); // RQ21
endmodule : power_fault_supervisor

// [sim/stage_model.sv]
// Power stages and off-ramp sequencer as seen from the supervisor.
// Assumes the bench injects stage faults and supply loss by level.
`timescale 1ns/1ns
module stage_model (
   input wire logic core_clk,
   input wire fault_sup_pkg::pwm_mode_e pwm_mode,
   input wire logic [fault_sup_pkg::NUM_PHASES-1:0] fault_inj,
   input wire logic [fault_sup_pkg::NUM_PHASES-1:0] vcc_low,
   output logic [fault_sup_pkg::NUM_PHASES-1:0] stage_fault_cmp,
   output logic [fault_sup_pkg::NUM_PHASES-1:0] stage_temp_low,
   output logic soft_off_done
);
   import fault_sup_pkg::*;
   // ----------------------------------------
   // Stage pins and ramp
   // ----------------------------------------
   int ramp_cnt;
   // Faulted stage pulls pin high
   assign stage_fault_cmp = fault_inj;
   // Unpowered stage holds pin low
   assign stage_temp_low = vcc_low;
   // Slow ramp keeps soft-off visible
   always_ff @(posedge core_clk) begin
      if (pwm_mode == PWM_SOFT_OFF) begin
         ramp_cnt <= ramp_cnt + 1;
      end else begin
         ramp_cnt <= 0;
      end
   end
   assign soft_off_done = (ramp_cnt >= 40);
endmodule : stage_model

// [sim/test_power_fault_supervisor.sv]
// Self-checking bench for the power fault supervisor.
// Assumes stage_model stands for the power stages and the sequencer.
`timescale 1ns/1ns
module test_power_fault_supervisor;
   import fault_sup_pkg::*;
   // ----------------------------------------
   // Signals and reference model
   // ----------------------------------------
   localparam int LIMIT = 20000;
   logic core_clk = 1'b0, rst = 1'b1, control_pin = 1'b1, init_done = 1'b1;
   logic vin_uv_fast = 1'b0, vout_ov_fast = 1'b0, vout_uv_fast = 1'b0, overcurrent_trip = 1'b0;
   logic feedback_sense_pos_open = 1'b0, feedback_sense_neg_open = 1'b0, cycle_start = 1'b0;
   logic limits_we = 1'b0, cfg_we = 1'b0, duty_limit_we = 1'b0, temp_cal_we = 1'b0;
   logic nvm_store = 1'b0, nvm_slot_blank = 1'b0, soft_off_done, seen;
   logic [3:0] comp_resistor_code = 4'h0, vsel_resistor_code = 4'h0, cfg_sel = 4'h4;
   logic [NUM_PHASES-1:0] stage_fault_cmp, stage_temp_low, fault_inj = '0, vcc_low = '0;
   logic [NUM_PHASES*8-1:0] phase_duty = 32'h40404040, temp_cal_wdata = '0;
   logic [7:0] duty_limit_wdata = 8'hE0;
   adc_s adc;
   limits_s limits_wdata;
   fault_cfg_s cfg_wdata;
   pwm_mode_e pwm_mode;
   logic output_enable_ok, vin_low_fault, vout_ov_warn, vout_uv_warn, stage_init_fault, nvm_store_refused;
   logic [NUM_FAULTS-1:0] fault_status;
   logic [NUM_PHASES-1:0] stage_fault_status_cmd;
   logic [1:0] sense_open_status;
   logic [3:0] comp_resistor_index_cmd, vsel_resistor_index_cmd;
   logic [NUM_PHASES*12-1:0] stage_temp_cal;
   logic [2:0] nvm_space_left_cmd;
   int err_total = 0, compares = 0, cycles = 0, ph;
   int seed = 32'h55f2;
   int resp_m[NUM_FAULTS] = '{3, 3, 3, 3, 3, 1, 1, 3, 3};
   int tmp[NUM_PHASES], off[NUM_PHASES];

   power_fault_supervisor uut (.*);
   stage_model far_side (.*);

   always #2 core_clk = ~core_clk;

   // Worst response among active faults
   function automatic int exp_mode(input int mask);
      int m = 0;
      for (int i = 0; i < NUM_FAULTS; i++) begin
         if (mask[i] && resp_m[i] > m) m = resp_m[i];
      end
      return m;
   endfunction : exp_mode
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wt
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   task automatic chk_mode(input int mask);
      chk("fault_status", mask, fault_status);
      chk("pwm_mode", exp_mode(mask), pwm_mode);
   endtask : chk_mode
   task automatic wait_bit(input int b, input logic v);
      for (int n = 0; n < 300 && fault_status[b] !== v; n++) wt(1);
      chk("fault_bit", v, fault_status[b]);
   endtask : wait_bit
   // Control pin fall clears latches
   task automatic clear();
      @(posedge core_clk);
      control_pin <= 1'b0;
      @(posedge core_clk);
      control_pin <= 1'b1;
      wt(4);
   endtask : clear
   task automatic do_reset();
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      wt(1);
   endtask : do_reset
   task automatic duty_case(input logic [7:0] d, input logic e);
      @(posedge core_clk);
      phase_duty[ph*8 +: 8] <= d;
      cycle_start <= 1'b1;
      @(posedge core_clk);
      cycle_start <= 1'b0;
      phase_duty <= 32'h40404040;
      wt(4);
      chk("balance_fault", e, fault_status[F_BALANCE]);
   endtask : duty_case
   // Refusal pulse gathered over a window
   task automatic store(input logic blank, input logic e, input int left);
      @(posedge core_clk);
      nvm_store <= 1'b1;
      nvm_slot_blank <= blank;
      @(posedge core_clk);
      nvm_store <= 1'b0;
      seen = 1'b0;
      repeat (3) begin
         #1 seen |= nvm_store_refused;
         @(posedge core_clk);
      end
      #1;
      chk("nvm_refused", e, seen);
      chk("nvm_left", left, nvm_space_left_cmd);
   endtask : store
   task automatic close_out();
      $display("Checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_total++;
         close_out();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      adc = '{12'h600, 12'h800, 12'h030, {4{12'h030}}};
      limits_wdata = '{12'hC00, 12'h200, 12'h300, 12'h280, 12'h900, 12'h700, 12'h500, 12'h07D, 12'h07D,
         12'h064, 12'h064};
      cfg_wdata = '{RESP_LOW, 3'h0, 8'h00};
      do_reset();
      chk("pwm_mode", PWM_HIZ, pwm_mode);
      chk("enable_ok", 0, output_enable_ok);
      chk("nvm_left", 7, nvm_space_left_cmd);
      @(posedge core_clk);
      limits_we <= 1'b1;
      @(posedge core_clk);
      limits_we <= 1'b0;
      clear();
      chk("vin_low", 0, vin_low_fault);
      chk("enable_ok", 1, output_enable_ok);
      @(posedge core_clk);
      overcurrent_trip <= 1'b1;
      wt(3);
      chk_mode(1 << F_OCP);
      @(posedge core_clk);
      overcurrent_trip <= 1'b0;
      wt(30);
      chk("pwm_mode", PWM_HIZ, pwm_mode);
      clear();
      chk("fault_status", 0, fault_status);
      $display("done overcurrent latch");
      for (int i = 0; i < NUM_PHASES; i++) begin
         @(posedge core_clk);
         fault_inj <= 4'(1 << i);
         wt(4);
         chk("stage_status", 1 << i, stage_fault_status_cmd);
         chk_mode(1 << F_STAGE);
         @(posedge core_clk);
         fault_inj <= '0;
         clear();
      end
      $display("done stage faults");
      @(posedge core_clk);
      cfg_we <= 1'b1;
      @(posedge core_clk);
      cfg_we <= 1'b0;
      resp_m[F_OCP] = 2;
      adc.temp_ctrl <= 12'h080;
      wt(4);
      chk_mode(1 << F_OT_CTRL);
      @(posedge core_clk);
      overcurrent_trip <= 1'b1;
      wt(4);
      chk_mode(1 << F_OT_CTRL | 1 << F_OCP);
      @(posedge core_clk);
      fault_inj <= 4'h1;
      wt(4);
      chk_mode(1 << F_OT_CTRL | 1 << F_OCP | 1 << F_STAGE);
      @(posedge core_clk);
      fault_inj <= 4'h0;
      overcurrent_trip <= 1'b0;
      adc.temp_ctrl <= 12'h030;
      clear();
      ph = $random(seed) & 3;
      @(posedge core_clk);
      adc.temp_stage[ph*12 +: 12] <= 12'h080;
      wt(4);
      chk_mode(1 << F_OT_STAGE);
      @(posedge core_clk);
      adc.temp_stage[ph*12 +: 12] <= 12'h030;
      wait_bit(F_OT_STAGE, 1'b0);
      $display("done severity and temperature");
      @(posedge core_clk);
      adc.vin <= 12'h100;
      wt(4);
      chk_mode(1 << F_VIN_UV);
      chk("vin_low", 1, vin_low_fault);
      @(posedge core_clk);
      adc.vin <= 12'h600;
      wait_bit(F_VIN_UV, 1'b0);
      @(posedge core_clk);
      adc.vin <= 12'hD00;
      wt(4);
      chk_mode(1 << F_VIN_OV);
      @(posedge core_clk);
      adc.vin <= 12'h600;
      vin_uv_fast <= 1'b1;
      clear();
      chk_mode(1 << F_VIN_UV);
      @(posedge core_clk);
      vin_uv_fast <= 1'b0;
      wait_bit(F_VIN_UV, 1'b0);
      @(posedge core_clk);
      adc.vout <= 12'h600;
      wt(4);
      chk("uv_warn", 1, vout_uv_warn);
      chk("fault_status", 0, fault_status);
      @(posedge core_clk);
      adc.vout <= 12'h400;
      wt(4);
      chk_mode(1 << F_VOUT_UV);
      chk("uv_warn", 0, vout_uv_warn);
      @(posedge core_clk);
      adc.vout <= 12'hA00;
      clear();
      chk("ov_warn", 1, vout_ov_warn);
      @(posedge core_clk);
      adc.vout <= 12'h800;
      vout_ov_fast <= 1'b1;
      vout_uv_fast <= 1'b1;
      wt(3);
      chk_mode(1 << F_VOUT_OV | 1 << F_VOUT_UV);
      @(posedge core_clk);
      vout_ov_fast <= 1'b0;
      vout_uv_fast <= 1'b0;
      clear();
      $display("done voltage limits");
      duty_case(8'hC8, 1'b1);
      clear();
      @(posedge core_clk);
      duty_limit_we <= 1'b1;
      @(posedge core_clk);
      duty_limit_we <= 1'b0;
      duty_case(8'hC8, 1'b0);
      duty_case(8'hE8, 1'b1);
      clear();
      for (int k = 0; k < 6; k++) begin
         @(posedge core_clk);
         comp_resistor_code <= 4'($random(seed));
         vsel_resistor_code <= 4'($random(seed));
         temp_cal_we <= 1'b1;
         for (int i = 0; i < NUM_PHASES; i++) begin
            tmp[i] = 32 + ($random(seed) & 31);
            off[i] = $random(seed) % 16;
            adc.temp_stage[i*12 +: 12] <= 12'(tmp[i]);
            temp_cal_wdata[i*8 +: 8] <= 8'(off[i]);
         end
         @(posedge core_clk);
         temp_cal_we <= 1'b0;
         wt(4);
         chk("comp_index", comp_resistor_code, comp_resistor_index_cmd);
         chk("vsel_index", vsel_resistor_code, vsel_resistor_index_cmd);
         for (int i = 0; i < NUM_PHASES; i++) begin
            chk("temp_cal", 12'(tmp[i] + off[i]), stage_temp_cal[i*12 +: 12]);
         end
      end
      $display("done duty, readback and calibration");
      store(1'b0, 1'b1, 7);
      for (int k = 6; k >= 0; k--) store(1'b1, 1'b0, k);
      store(1'b1, 1'b1, 0);
      @(posedge core_clk);
      feedback_sense_pos_open <= 1'b1;
      vcc_low <= 4'h4;
      init_done <= 1'b0;
      do_reset();
      @(posedge core_clk);
      init_done <= 1'b1;
      wt(8);
      chk("sense_open", 2'b01, sense_open_status);
      chk("init_fault", 1, stage_init_fault);
      chk("nvm_left", 7, nvm_space_left_cmd);
      duty_case(8'hC8, 1'b1);
      $display("done store and second reset");
      close_out();
   end
endmodule : test_power_fault_supervisor
